// ---- drive_seq_pkg.sv ----
// Purpose: Shared types and constants for the drive on/off sequencer
// Assumes: One system clock, active-low asynchronous power-up reset
// Notes:   Macro codes other than two-wire scheme 1 are local values
package drive_seq_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned DI_COUNT    = 6;
  localparam int unsigned ROUTE_W     = 3;
  localparam int unsigned MACRO_W     = 8;

  // ************************************************************
  // Control macro codes
  // ************************************************************
  localparam logic [MACRO_W-1:0] MACRO_TWO_WIRE_1   = 8'h0c;
  localparam logic [MACRO_W-1:0] MACRO_TWO_WIRE_2   = 8'h11;
  localparam logic [MACRO_W-1:0] MACRO_TWO_WIRE_3   = 8'h12;
  localparam logic [MACRO_W-1:0] MACRO_THREE_WIRE_1 = 8'h13;
  localparam logic [MACRO_W-1:0] MACRO_THREE_WIRE_2 = 8'h14;

  // ************************************************************
  // Fixed input positions for three-wire schemes
  // ************************************************************
  localparam logic [ROUTE_W-1:0] DI_ENABLE_POS  = 3'h0;
  localparam logic [ROUTE_W-1:0] DI_START_POS   = 3'h1;
  localparam logic [ROUTE_W-1:0] DI_THIRD_POS   = 3'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_LOCKOUT,
    ST_READY_TO_START,
    ST_READY,
    ST_OPERATION,
    ST_NORMAL_STOP,
    ST_QUICK_STOP
  } seq_state_t;

  // Outputs handed to the motor control path
  typedef struct packed {
    logic energise;
    logic ramp_active;
    logic quick_ramp;
    logic reverse;
    logic lockout;
  } drive_out_t;

  // Latches kept by the input decoder
  typedef struct packed {
    logic run;
    logic ccw;
  } decode_state_t;

  // Sequencer state
  typedef struct packed {
    seq_state_t state;
    drive_out_t out;
  } seq_regs_t;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam drive_out_t    DRIVE_OUT_RESET = '{default: 1'b0};
  localparam decode_state_t DECODE_RESET    = '{default: 1'b0};
  localparam seq_state_t    STATE_RESET     = ST_POWER_UP;

endpackage

// ---- di_command_decoder.sv ----
// Purpose: Decode digital inputs into run and direction per macro
// Assumes: Inputs synchronous to clk_i
// Notes:   Outputs are combinational; the sequencer registers them
`timescale 1ns/10ps
module di_command_decoder (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                reset_n_i,
  // Configuration
  input  wire logic [drive_seq_pkg::MACRO_W-1:0]   control_macro_select_i,
  input  wire logic [drive_seq_pkg::ROUTE_W-1:0]   run_input_route_i,
  input  wire logic [drive_seq_pkg::ROUTE_W-1:0]   reverse_input_route_i,
  // Inputs
  input  wire logic [drive_seq_pkg::DI_COUNT-1:0]  digital_input_i,
  input  wire logic                                speed_zero_i,
  // Decoded commands
  output logic                                     run_o,
  output logic                                     reverse_o
);
  import drive_seq_pkg::*;

  decode_state_t st;
  decode_state_t next_st;
  logic          first_in;
  logic          second_in;
  logic          enable_in;
  logic          start_in;
  logic          third_in;

  // Pick one input by selector; out-of-range selectors read inactive
  function automatic logic pick(input logic [DI_COUNT-1:0] di, input logic [ROUTE_W-1:0] idx);
    pick = (32'(idx) < DI_COUNT) ? di[idx] : 1'b0;
  endfunction

  // Routed and fixed inputs
  always_comb begin
    first_in  = pick(digital_input_i, run_input_route_i);
    second_in = pick(digital_input_i, reverse_input_route_i);
    enable_in = pick(digital_input_i, DI_ENABLE_POS);
    start_in  = pick(digital_input_i, DI_START_POS);
    third_in  = pick(digital_input_i, DI_THIRD_POS);
  end

  // Scheme decode and latch update
  always_comb begin
    next_st   = st;
    run_o     = 1'b0;
    reverse_o = 1'b0;
    case (control_macro_select_i)
      MACRO_TWO_WIRE_1: begin
        run_o     = first_in;
        reverse_o = first_in & second_in;
      end
      MACRO_TWO_WIRE_2: begin
        // Direction follows the input that rose first, changed only at standstill
        if (speed_zero_i && (first_in ^ second_in)) begin
          next_st.ccw = second_in;
        end
        run_o     = first_in | second_in;
        reverse_o = next_st.ccw;
      end
      MACRO_TWO_WIRE_3: begin
        run_o     = first_in ^ second_in;
        reverse_o = second_in & ~first_in;
      end
      MACRO_THREE_WIRE_1: begin
        if (!enable_in) begin
          next_st.run = 1'b0;
        end else if (start_in) begin
          next_st.run = 1'b1;
          next_st.ccw = 1'b0;
        end else if (third_in) begin
          next_st.run = 1'b1;
          next_st.ccw = 1'b1;
        end
        run_o     = next_st.run;
        reverse_o = next_st.ccw;
      end
      MACRO_THREE_WIRE_2: begin
        if (!enable_in) begin
          next_st.run = 1'b0;
        end else if (start_in) begin
          next_st.run = 1'b1;
        end
        next_st.ccw = third_in;
        run_o     = next_st.run;
        reverse_o = third_in;
      end
      default: begin
        next_st = DECODE_RESET;
      end
    endcase
  end

  // Latch register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= DECODE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Two-wire scheme 1 never runs with its run input inactive
  a_scheme1_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (control_macro_select_i == MACRO_TWO_WIRE_1 && !first_in) |-> (!run_o && !reverse_o))
    else $error("scheme 1 runs with run input inactive");

endmodule

// ---- drive_on_off_sequencer.sv ----
// Purpose: Switch-on and switch-off sequence control of a motor drive
// Assumes: Commands synchronous to clk_i; speed zero from motor control
// Notes:   All outputs registered; one state change per clock
`timescale 1ns/10ps
module drive_on_off_sequencer (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                reset_n_i,
  // Configuration
  input  wire logic [drive_seq_pkg::MACRO_W-1:0]   control_macro_select_i,
  input  wire logic [drive_seq_pkg::ROUTE_W-1:0]   run_input_route_i,
  input  wire logic [drive_seq_pkg::ROUTE_W-1:0]   reverse_input_route_i,
  input  wire logic                                fieldbus_mode_i,
  input  wire logic                                auto_start_i,
  // Digital inputs
  input  wire logic [drive_seq_pkg::DI_COUNT-1:0]  digital_input_i,
  // Fieldbus control word bits
  input  wire logic                                fb_run_i,
  input  wire logic                                fb_reverse_i,
  input  wire logic                                fb_operation_enable_i,
  // Stop commands
  input  wire logic                                coast_stop_cmd_i,
  input  wire logic                                quick_stop_cmd_i,
  // Motor control feedback
  input  wire logic                                speed_zero_i,
  // Drive outputs
  output logic                                     motor_energise_o,
  output logic                                     ramp_active_o,
  output logic                                     quick_ramp_o,
  output logic                                     reverse_o,
  output logic                                     lockout_o,
  output drive_seq_pkg::seq_state_t                state_o
);
  import drive_seq_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  seq_regs_t st;
  seq_regs_t next_st;
  logic      di_run;
  logic      di_reverse;
  logic      run_cmd;
  logic      reverse_cmd;
  logic      ramp_stop_cmd;
  logic      coast_stop_cmd;
  logic      quick_stop_cmd;
  logic      operation_enable;

  // ************************************************************
  // Digital input decoder
  // ************************************************************
  di_command_decoder u_decoder (
    .clk_i                  (clk_i),
    .reset_n_i              (reset_n_i),
    .control_macro_select_i (control_macro_select_i),
    .run_input_route_i      (run_input_route_i),
    .reverse_input_route_i  (reverse_input_route_i),
    .digital_input_i        (digital_input_i),
    .speed_zero_i           (speed_zero_i),
    .run_o                  (di_run),
    .reverse_o              (di_reverse)
  );

  // ************************************************************
  // Command source selection
  // ************************************************************
  // Run and direction from fieldbus or digital inputs; enable from fieldbus, tied high under digital inputs
  always_comb begin
    run_cmd          = fieldbus_mode_i ? fb_run_i : di_run;
    reverse_cmd      = fieldbus_mode_i ? fb_reverse_i : di_reverse;
    operation_enable = fieldbus_mode_i ? fb_operation_enable_i : 1'b1;
    // Stop priority: coast over quick over ramp
    coast_stop_cmd   = coast_stop_cmd_i;
    quick_stop_cmd   = quick_stop_cmd_i & ~coast_stop_cmd_i;
    ramp_stop_cmd    = ~run_cmd & ~coast_stop_cmd_i & ~quick_stop_cmd_i;
  end

  // ************************************************************
  // Sequence state machine
  // ************************************************************
  // Next state and output flags
  always_comb begin
    next_st = st;
    case (st.state)
      // First edge after reset samples run and the stops
      ST_POWER_UP: begin
        if (coast_stop_cmd || quick_stop_cmd) begin
          next_st.state = ST_LOCKOUT;
        end else if (run_cmd && !auto_start_i) begin
          next_st.state = ST_LOCKOUT;
        end else begin
          next_st.state = ST_READY_TO_START;
        end
      end
      ST_LOCKOUT: begin
        // Leave only once switch-on has been withdrawn
        if (!run_cmd && !coast_stop_cmd && !quick_stop_cmd) begin
          next_st.state = ST_READY_TO_START;
        end
      end
      // Idle with the motor off, waiting for switch-on
      ST_READY_TO_START: begin
        if (coast_stop_cmd || quick_stop_cmd) begin
          next_st.state = ST_LOCKOUT;
        end else if (run_cmd) begin
          next_st.state = ST_READY;
        end
      end
      // Switched on, waiting for the operating enable
      ST_READY: begin
        if (coast_stop_cmd || quick_stop_cmd) begin
          next_st.state = ST_LOCKOUT;
        end else if (ramp_stop_cmd) begin
          next_st.state = ST_READY_TO_START;
        end else if (operation_enable) begin
          next_st.state = ST_OPERATION;
        end
      end
      // Motor driven; stops taken in priority order
      ST_OPERATION: begin
        if (coast_stop_cmd) begin
          next_st.state = ST_LOCKOUT;
        end else if (quick_stop_cmd) begin
          next_st.state = ST_QUICK_STOP;
        end else if (ramp_stop_cmd) begin
          next_st.state = ST_NORMAL_STOP;
        end
      end
      // Braking on the normal ramp
      ST_NORMAL_STOP: begin
        if (coast_stop_cmd) begin
          next_st.state = ST_LOCKOUT;
        end else if (quick_stop_cmd) begin
          next_st.state = ST_QUICK_STOP;
        end else if (speed_zero_i) begin
          next_st.state = ST_READY_TO_START;
        end
      end
      // Braking on the quick ramp, then lockout
      ST_QUICK_STOP: begin
        if (coast_stop_cmd) begin
          next_st.state = ST_LOCKOUT;
        end else if (speed_zero_i) begin
          next_st.state = ST_LOCKOUT;
        end
      end
      // Unused codes fall back to lockout
      default: begin
        next_st.state = ST_LOCKOUT;
      end
    endcase

    // Output flags follow the state being entered
    next_st.out.energise    = (next_st.state == ST_OPERATION) ||
                              (next_st.state == ST_NORMAL_STOP) ||
                              (next_st.state == ST_QUICK_STOP);
    next_st.out.ramp_active = (next_st.state == ST_NORMAL_STOP) ||
                              (next_st.state == ST_QUICK_STOP);
    next_st.out.quick_ramp  = (next_st.state == ST_QUICK_STOP);
    next_st.out.lockout     = (next_st.state == ST_LOCKOUT);
    // Direction is held while braking so the ramp keeps its sense
    if (next_st.state == ST_OPERATION) begin
      next_st.out.reverse = reverse_cmd;
    end else if (!next_st.out.ramp_active) begin
      next_st.out.reverse = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st.state <= STATE_RESET;
      st.out   <= DRIVE_OUT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Straight from the state register
  always_comb begin
    motor_energise_o = st.out.energise;
    ramp_active_o    = st.out.ramp_active;
    quick_ramp_o     = st.out.quick_ramp;
    reverse_o        = st.out.reverse;
    lockout_o        = st.out.lockout;
    state_o          = st.state;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_powerup_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_POWER_UP && !run_cmd && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_READY_TO_START && !motor_energise_o))
    else $error("power-up did not reach ready to start");

  a_switch_on: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_READY && run_cmd && operation_enable && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_OPERATION && motor_energise_o && !ramp_active_o))
    else $error("switch-on did not energise the motor");

  a_ramp_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_OPERATION && ramp_stop_cmd)
      |=> (st.state == ST_NORMAL_STOP && ramp_active_o && !quick_ramp_o && motor_energise_o))
    else $error("ramp stop did not start the normal ramp");

  a_ramp_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_NORMAL_STOP && speed_zero_i && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_READY_TO_START && !motor_energise_o && !ramp_active_o))
    else $error("normal stop did not end at standstill");

  a_coast_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (coast_stop_cmd_i && st.state != ST_POWER_UP)
      |=> (!motor_energise_o && !ramp_active_o && lockout_o))
    else $error("coast stop did not de-energise at once");

  a_quick_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_OPERATION && quick_stop_cmd_i && !coast_stop_cmd_i)
      |=> (st.state == ST_QUICK_STOP && quick_ramp_o) ##1 (st.state != ST_NORMAL_STOP))
    else $error("quick stop lost priority");

  a_quick_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_QUICK_STOP && speed_zero_i)
      |=> (st.state == ST_LOCKOUT && !motor_energise_o))
    else $error("quick stop did not end in lockout");

  a_lockout_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_LOCKOUT && run_cmd) |=> (st.state == ST_LOCKOUT && !motor_energise_o))
    else $error("lockout reacted to switch-on");

  a_powerup_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_POWER_UP && run_cmd && !auto_start_i) |=> lockout_o)
    else $error("held switch-on at power-up not locked out");

  a_auto_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_POWER_UP && run_cmd && auto_start_i && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_READY_TO_START) ##1 (st.state != ST_LOCKOUT))
    else $error("automatic start did not accept switch-on");

  a_wait_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_READY && fieldbus_mode_i && !fb_operation_enable_i && run_cmd
      && !coast_stop_cmd_i && !quick_stop_cmd_i) |=> (st.state == ST_READY && !motor_energise_o))
    else $error("ready left without operating enable");

  a_di_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_READY && !fieldbus_mode_i && run_cmd && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_OPERATION))
    else $error("digital-input control lacked automatic enable");

  a_stop_lockout: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_READY_TO_START && (coast_stop_cmd_i || quick_stop_cmd_i)) |=> lockout_o)
    else $error("stop command did not lock out");

  // ************************************************************
  // Checks on stop priority, flags, routing and leaving ready, lockout and power-up
  // ************************************************************
  a_quick_over_ramp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_NORMAL_STOP && quick_stop_cmd_i && !coast_stop_cmd_i)
      |=> (st.state == ST_QUICK_STOP && quick_ramp_o && motor_energise_o))
    else $error("quick stop did not cut the normal ramp");

  a_coast_quick: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_QUICK_STOP && coast_stop_cmd_i)
      |=> (st.state == ST_LOCKOUT && !motor_energise_o && !ramp_active_o))
    else $error("coast stop did not end the quick ramp");

  a_coast_ramp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_NORMAL_STOP && coast_stop_cmd_i)
      |=> (st.state == ST_LOCKOUT && !motor_energise_o && !ramp_active_o))
    else $error("coast stop did not end the normal ramp");

  a_ramp_flags: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ramp_active_o
      |-> (motor_energise_o && (state_o == ST_NORMAL_STOP || state_o == ST_QUICK_STOP)))
    else $error("ramp flag outside a braking state");

  a_quick_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    quick_ramp_o
      |-> (ramp_active_o && state_o == ST_QUICK_STOP))
    else $error("quick ramp flag outside quick stop");

  a_lockout_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    lockout_o
      |-> (state_o == ST_LOCKOUT && !motor_energise_o && !reverse_o))
    else $error("lockout flag with the motor driven");

  a_ready_withdraw: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_READY && !run_cmd && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_READY_TO_START && !motor_energise_o))
    else $error("ready kept after run withdrawn");

  a_brake_dir: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ramp_active_o && !coast_stop_cmd_i && !speed_zero_i)
      |=> (ramp_active_o && $stable(reverse_o)))
    else $error("direction changed while braking");

  a_route_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!fieldbus_mode_i && control_macro_select_i == MACRO_TWO_WIRE_1 && 32'(run_input_route_i) < DI_COUNT)
      |-> (run_cmd == digital_input_i[run_input_route_i]))
    else $error("run not taken from the routed input");

  a_route_reverse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!fieldbus_mode_i && control_macro_select_i == MACRO_TWO_WIRE_1 && 32'(reverse_input_route_i) < DI_COUNT)
      |-> (reverse_cmd == (run_cmd && digital_input_i[reverse_input_route_i])))
    else $error("reverse not taken from the routed input");

  a_lockout_leave: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_LOCKOUT && !run_cmd && !coast_stop_cmd_i && !quick_stop_cmd_i)
      |=> (st.state == ST_READY_TO_START && !lockout_o))
    else $error("lockout kept after switch-on withdrawn");

  a_quick_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_READY && quick_stop_cmd_i)
      |=> (lockout_o && !motor_energise_o))
    else $error("quick stop in ready did not lock out");

  a_powerup_once: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st.state == ST_POWER_UP)
      |=> (st.state == ST_LOCKOUT || st.state == ST_READY_TO_START))
    else $error("power-up state held");

endmodule

// ---- motor_path_model.sv ----
// Purpose: Behavioural motor control path that reports standstill
// Assumes: Braking lasts BRAKE_CYC clocks once a ramp starts
// Notes:   Speed zero is high whenever the motor is not energised
`timescale 1ns/10ps
module motor_path_model #(
  parameter int unsigned BRAKE_CYC = 4
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Drive state
  input  wire logic energise_i,
  input  wire logic ramp_active_i,
  // Standstill
  output logic      speed_zero_o
);
  logic [7:0] brake_count;

  // ************************************************************
  // Braking timer
  // ************************************************************
  // Counts clocks of an active ramp, restarts when the ramp ends
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brake_count <= 8'h00;
    end else if (ramp_active_i && brake_count != 8'hff) begin
      brake_count <= brake_count + 8'h01;
    end else if (!ramp_active_i) begin
      brake_count <= 8'h00;
    end
  end

  // Standstill once the ramp has run its course
  assign speed_zero_o = !energise_i || (ramp_active_i && brake_count >= BRAKE_CYC);
endmodule

// ---- tb_drive_on_off_sequencer.sv ----
// Purpose: Self-checking bench of the drive on/off sequencer
// Assumes: Inputs change on the falling edge, outputs read there too
// Notes:   Expected vector is {energise, ramp, quick, reverse, lockout}
`timescale 1ns/10ps
module tb_drive_on_off_sequencer;
  import drive_seq_pkg::*;
  logic                clk_i = 1'b0;
  logic                reset_n_i = 1'b0;
  logic [MACRO_W-1:0]  macro = MACRO_TWO_WIRE_1;
  logic [ROUTE_W-1:0]  run_rt = 3'h0;
  logic [ROUTE_W-1:0]  rev_rt = 3'h1;
  logic                fb_mode = 1'b0;
  logic                auto_st = 1'b0;
  logic [DI_COUNT-1:0] di = '0;
  logic                fb_run = 1'b0;
  logic                fb_rev = 1'b0;
  logic                fb_en = 1'b0;
  logic                coast = 1'b0;
  logic                quick = 1'b0;
  logic                speed_zero;
  logic                energise, ramp, qramp, rev, lock;
  seq_state_t          state;
  int                  err_total = 0;
  int                  checks_done = 0;

  // ************************************************************
  // Clock, design and motor path
  // ************************************************************
  initial forever #12.5 clk_i = ~clk_i;
  drive_on_off_sequencer dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .control_macro_select_i(macro),
    .run_input_route_i(run_rt), .reverse_input_route_i(rev_rt), .fieldbus_mode_i(fb_mode),
    .auto_start_i(auto_st), .digital_input_i(di), .fb_run_i(fb_run), .fb_reverse_i(fb_rev),
    .fb_operation_enable_i(fb_en), .coast_stop_cmd_i(coast), .quick_stop_cmd_i(quick),
    .speed_zero_i(speed_zero), .motor_energise_o(energise), .ramp_active_o(ramp),
    .quick_ramp_o(qramp), .reverse_o(rev), .lockout_o(lock), .state_o(state));
  motor_path_model #(.BRAKE_CYC(4)) motor_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .energise_i(energise), .ramp_active_i(ramp), .speed_zero_o(speed_zero));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare state and output vector
  task automatic chk(input seq_state_t es, input logic [4:0] eo, input string msg);
    checks_done++;
    if (state !== es || {energise, ramp, qramp, rev, lock} !== eo) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Bounded wait for a state
  task automatic wait_st(input seq_state_t es);
    for (int i = 0; i < 50; i++) begin
      if (state === es) return;
      @(negedge clk_i);
    end
    err_total++;
    $display("[FAIL] %0t state wait ran out", $time);
    stop_test();
  endtask

  // Power-up with the run contact at a given level
  task automatic power_up(input logic run);
    reset_n_i = 1'b0;
    di = '0;
    cyc(3);
    chk(ST_POWER_UP, 5'h00, "reset values");
    reset_n_i = 1'b1;
    di = {5'h00, run}; // Run only once power is up
    cyc(1);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    power_up(1'b0);
    chk(ST_READY_TO_START, 5'h00, "power-up state");
    di = 6'h03;
    cyc(1);
    chk(ST_READY, 5'h00, "ready on run");
    cyc(1);
    chk(ST_OPERATION, 5'h12, "operation reversed");
    di = 6'h01;
    cyc(1);
    chk(ST_OPERATION, 5'h10, "clockwise");
    di = 6'h00;
    cyc(1);
    chk(ST_NORMAL_STOP, 5'h18, "ramp stop");
    cyc(2);
    chk(ST_NORMAL_STOP, 5'h18, "ramp until standstill");
    wait_st(ST_READY_TO_START);
    chk(ST_READY_TO_START, 5'h00, "ramp stop end");
    $display("test normal run done");
    di = 6'h01;
    cyc(2);
    quick = 1'b1;
    cyc(1);
    chk(ST_QUICK_STOP, 5'h1c, "quick ramp");
    wait_st(ST_LOCKOUT);
    cyc(3);
    chk(ST_LOCKOUT, 5'h01, "lockout ignores run");
    quick = 1'b0;
    di = 6'h00;
    cyc(1);
    chk(ST_READY_TO_START, 5'h00, "lockout left");
    $display("test quick stop done");
    di = 6'h01;
    cyc(2);
    {coast, quick, di} = {2'b11, 6'h00};
    cyc(1);
    chk(ST_LOCKOUT, 5'h01, "coast beats all");
    {coast, quick} = 2'b00;
    cyc(1);
    di = 6'h01;
    cyc(2);
    {quick, di} = {1'b1, 6'h00};
    cyc(1);
    chk(ST_QUICK_STOP, 5'h1c, "quick beats ramp");
    wait_st(ST_LOCKOUT);
    quick = 1'b0;
    cyc(1);
    $display("test priority done");
    run_rt = 3'h3;
    di = 6'h08;
    cyc(2);
    chk(ST_OPERATION, 5'h10, "routed run");
    di = 6'h00;
    wait_st(ST_READY_TO_START);
    run_rt = 3'h0;
    macro = 8'h00;
    di = 6'h01;
    cyc(2);
    chk(ST_READY_TO_START, 5'h00, "no scheme no run");
    macro = MACRO_TWO_WIRE_3;
    di = 6'h03;
    cyc(2);
    chk(ST_READY_TO_START, 5'h00, "both on stops");
    di = 6'h02;
    cyc(2);
    chk(ST_OPERATION, 5'h12, "ccw run input");
    di = 6'h00;
    wait_st(ST_READY_TO_START);
    macro = MACRO_TWO_WIRE_1;
    $display("test routing done");
    macro = MACRO_TWO_WIRE_2;
    di = 6'h02;
    cyc(2);
    chk(ST_OPERATION, 5'h12, "second input runs ccw");
    di = 6'h03;
    cyc(1);
    chk(ST_OPERATION, 5'h12, "first risen keeps direction");
    di = 6'h01;
    cyc(1);
    chk(ST_OPERATION, 5'h12, "direction held while turning");
    di = 6'h00;
    wait_st(ST_READY_TO_START);
    macro = MACRO_THREE_WIRE_1;
    di = 6'h05;
    cyc(2);
    chk(ST_OPERATION, 5'h12, "start ccw");
    di = 6'h01;
    cyc(1);
    chk(ST_OPERATION, 5'h12, "start latched");
    di = 6'h00;
    cyc(1);
    chk(ST_NORMAL_STOP, 5'h1a, "enable removed stops");
    wait_st(ST_READY_TO_START);
    macro = MACRO_THREE_WIRE_2;
    di = 6'h03;
    cyc(2);
    chk(ST_OPERATION, 5'h10, "start cw");
    di = 6'h05;
    cyc(1);
    chk(ST_OPERATION, 5'h12, "reverse input");
    di = 6'h00;
    wait_st(ST_READY_TO_START);
    macro = MACRO_TWO_WIRE_1;
    $display("test schemes done");
    {fb_mode, fb_run, fb_rev} = 3'b111;
    cyc(3);
    chk(ST_READY, 5'h00, "waits for enable");
    fb_en = 1'b1;
    cyc(1);
    chk(ST_OPERATION, 5'h12, "enable runs");
    {fb_run, fb_en} = 2'b00;
    wait_st(ST_READY_TO_START);
    {fb_mode, fb_rev} = 2'b00;
    $display("test fieldbus done");
    power_up(1'b1);
    chk(ST_LOCKOUT, 5'h01, "run held at power-up");
    di = 6'h00;
    cyc(1);
    chk(ST_READY_TO_START, 5'h00, "run withdrawn");
    auto_st = 1'b1;
    power_up(1'b1);
    cyc(2);
    chk(ST_OPERATION, 5'h10, "automatic start");
    $display("test power-up done");
    stop_test();
  end
endmodule
